// ---- seconds_pkg.sv ----
// Constants shared by the elapsed-seconds timekeeper with countdown alarm.
// Behaviour
// - Pointer steps per byte; past the last register it wraps to zero.
// - Start, stop or pointer wrap copies the seconds count into the shadow.
// - The seconds count is a 32-bit up counter at bytes zero to three.
// - Writing the seconds count resets its one-second divider stage only.
// - The 1Hz wave restarts with that divider; faster rates are undisturbed.
// - With the counter enable bit low the countdown bytes are plain storage.
// - An all-zero countdown keeps counting off whatever the enable bit.
// - Alarm mode counts down each second; at zero it flags and reloads.
// - The countdown flag stays set until software writes it to zero or a watchdog pulse ends.
// - In alarm mode with irq routed, the pin is low while flagged.
// - Watchdog mode decrements 4096 times per second.
// - Watchdog reads of countdown bytes reload; writes set seed and reload.
// - A strobe rising edge reloads the watchdog; a static level is ignored.
// - Watchdog expiry sets the flag and halts the counter.
// - Routed watchdog expiry pulses the pin low 250ms, then clears flag.
// - Clearing the flag or irq enable does not shorten the watchdog pulse.
// - A countdown write during the pulse defers counting until it ends.
// - Oscillator disable stops the oscillator and reads zero after reset.
// - Pin select low, oscillator running: the pin carries the chosen wave.
// - The countdown flag is set on every expiry whatever the pin routing.
// - Software writes of one to the countdown flag are ignored.
// - Oscillator stops set the halt flag; only a zero write clears it.
package seconds_pkg;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [3:0] ADDR_SEC0 = 4'h0;
    localparam logic [3:0] ADDR_SEC3 = 4'h3;
    localparam logic [3:0] ADDR_CD0 = 4'h4;
    localparam logic [3:0] ADDR_CD1 = 4'h5;
    localparam logic [3:0] ADDR_CD2 = 4'h6;
    localparam logic [3:0] ADDR_CTRL = 4'h7;
    localparam logic [3:0] ADDR_FLAGS = 4'h8;
    localparam logic [3:0] ADDR_FIRST = 4'h0;
    localparam logic [3:0] ADDR_LAST = 4'h8;
    localparam logic [7:0] CTRL_RESET = 8'h06;
    localparam int CTRL_OSC_DIS = 7;
    localparam int CTRL_CD_EN = 6;
    localparam int CTRL_WD_SEL = 5;
    localparam int CTRL_PIN_SEL = 3;
    localparam int CTRL_RATE_HI = 2;
    localparam int CTRL_RATE_LO = 1;
    localparam int CTRL_IRQ_EN = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hEF;
    localparam int FLAG_HALT = 7;
    localparam int FLAG_CD = 0;

    // ************************************************************
    // Link operations carried across the clock crossing
    // ************************************************************
    localparam logic [2:0] OP_START = 3'h1;
    localparam logic [2:0] OP_STOP = 3'h2;
    localparam logic [2:0] OP_ADDR = 3'h3;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_READ = 3'h5;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int REF_HZ = 40000000;
    localparam int PULSE_MS = 250;
    localparam int PULSE_CYCLES = PULSE_MS * (REF_HZ / 1000);
    localparam int OSC_STALL_CYCLES = 4000;
    localparam logic [2:0] PRESC_LAST = 3'h7;
    localparam logic [11:0] SEC_DIV_LAST = 12'hFFF;
    localparam logic [1:0] RATE_1HZ = 2'h0;
    localparam logic [1:0] RATE_4K = 2'h1;
    localparam logic [1:0] RATE_8K = 2'h2;

endpackage

// ---- seconds_timekeeper.sv ----
// Elapsed-seconds timekeeper with countdown alarm or watchdog.
`timescale 1ns/100ps
`default_nettype none

module seconds_timekeeper
    import seconds_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES,
    parameter int STALL_LEN = OSC_STALL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic osc_clk,
    input wire logic strobe_input,
    input wire logic link_clk,
    input wire logic link_start,
    input wire logic link_stop,
    input wire logic link_addr_wr,
    input wire logic link_data_wr,
    input wire logic link_data_rd,
    input wire logic [7:0] link_wdata,
    output logic link_busy,
    output logic [7:0] link_rdata,
    output logic wave_or_irq_out,
    output logic wave_or_irq_oe
);

    initial begin
        if (PULSE_LEN < 2 || PULSE_LEN > 32'h0FFFFFFF || STALL_LEN < 8
            || STALL_LEN > 32'h1FFF) begin
            $error("seconds_timekeeper: unusable timing parameters");
        end
    end

    // ************************************************************
    // Link side: hold one operation and toggle a request
    // ************************************************************
    logic [2:0] op_hold_r;
    logic [7:0] wdata_hold_r;
    logic req_tgl_r;
    logic ack_l1_r;
    logic ack_l2_r;
    logic ack_tgl_r;
    logic [7:0] rdata_hold_r;
    logic link_any;
    logic [2:0] link_op;

    // Only one operation may be in flight; new pulses while busy are dropped.
    assign link_busy = req_tgl_r ^ ack_l2_r;
    assign link_any = link_start | link_stop | link_addr_wr | link_data_wr
                      | link_data_rd;
    assign link_op = link_start ? OP_START : link_stop ? OP_STOP :
                     link_addr_wr ? OP_ADDR : link_data_wr ? OP_WRITE : OP_READ;

    // Request launch; op and data stay stable until the answer returns.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            op_hold_r <= 3'h0;
            wdata_hold_r <= 8'h00;
            req_tgl_r <= 1'b0;
        end else if (link_any && !link_busy) begin
            op_hold_r <= link_op;
            wdata_hold_r <= link_wdata;
            req_tgl_r <= ~req_tgl_r;
        end
    end

    // Answer synchroniser and read data capture, taken once the ack lands.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            ack_l1_r <= 1'b0;
            ack_l2_r <= 1'b0;
            link_rdata <= 8'h00;
        end else begin
            ack_l1_r <= ack_tgl_r;
            ack_l2_r <= ack_l1_r;
            if (ack_l2_r != ack_l1_r) begin
                link_rdata <= rdata_hold_r;
            end
        end
    end

    // ************************************************************
    // Reference side: synchronisers
    // ************************************************************
    logic req_s1_r, req_s2_r, req_s3_r;
    logic osc_s1_r, osc_s2_r, osc_s3_r;
    logic stb_s1_r, stb_s2_r, stb_s3_r;

    // Two flops per foreign signal; the third only serves edge detection.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {req_s1_r, req_s2_r, req_s3_r} <= 3'h0;
            {osc_s1_r, osc_s2_r, osc_s3_r} <= 3'h0;
            {stb_s1_r, stb_s2_r, stb_s3_r} <= 3'h0;
        end else if (ce) begin
            {req_s1_r, req_s2_r, req_s3_r} <= {req_tgl_r, req_s1_r, req_s2_r};
            {osc_s1_r, osc_s2_r, osc_s3_r} <= {osc_clk, osc_s1_r, osc_s2_r};
            {stb_s1_r, stb_s2_r, stb_s3_r} <= {strobe_input, stb_s1_r,
                                               stb_s2_r};
        end
    end

    logic req_seen;
    logic osc_rise;
    logic strobe_rise;
    assign req_seen = ce && (req_s2_r != req_s3_r);
    assign osc_rise = osc_s2_r && !osc_s3_r;
    assign strobe_rise = ce && stb_s2_r && !stb_s3_r;

    // ************************************************************
    // Register access decode and pointer
    // ************************************************************
    logic [3:0] ptr_r;
    logic [7:0] ctrl_r;
    logic do_wr, do_rd, do_snap;
    logic [3:0] ptr_nxt;
    assign do_wr = req_seen && op_hold_r == OP_WRITE;
    assign do_rd = req_seen && op_hold_r == OP_READ;
    assign ptr_nxt = (ptr_r == ADDR_LAST) ? ADDR_FIRST : ptr_r + 4'h1;
    assign do_snap = req_seen && (op_hold_r == OP_START || op_hold_r == OP_STOP
                     || ((do_wr || do_rd) && ptr_r == ADDR_LAST));

    // Pointer loads on an address byte and steps after every data byte.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr_r <= ADDR_FIRST;
        end else if (ce) begin
            if (req_seen && op_hold_r == OP_ADDR) begin
                ptr_r <= (link_wdata_addr() > ADDR_LAST) ? ADDR_FIRST
                                                         : link_wdata_addr();
            end else if (do_wr || do_rd) begin
                ptr_r <= ptr_nxt;
            end
        end
    end

    function automatic logic [3:0] link_wdata_addr();
        return wdata_hold_r[3:0];
    endfunction

    // Answer toggles one cycle after the request is taken.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_tgl_r <= 1'b0;
        end else if (req_seen) begin
            ack_tgl_r <= req_s2_r;
        end
    end

    // ************************************************************
    // Oscillator divider chain
    // ************************************************************
    logic [2:0] presc_r;
    logic [11:0] sec_div_r;
    logic wd_tick, sec_tick, sec_wr;
    logic osc_run;
    assign osc_run = !ctrl_r[CTRL_OSC_DIS];
    assign wd_tick = ce && osc_run && osc_rise && presc_r == PRESC_LAST;
    assign sec_tick = wd_tick && sec_div_r == SEC_DIV_LAST;
    assign sec_wr = do_wr && ptr_r <= ADDR_SEC3;

    // Prescaler to 4096 Hz; never touched by seconds writes.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc_r <= 3'h0;
        end else if (ce && osc_run && osc_rise) begin
            presc_r <= presc_r + 3'h1;
        end
    end

    // One-second stage, restarted by any seconds byte write.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sec_div_r <= 12'h000;
        end else if (ce) begin
            if (sec_wr) begin
                sec_div_r <= 12'h000;
            end else if (wd_tick) begin
                sec_div_r <= sec_div_r + 12'h001;
            end
        end
    end

    // ************************************************************
    // Seconds counter and shadow
    // ************************************************************
    logic [31:0] secs_r;
    logic [31:0] shadow_r;

    // Running count; a byte write replaces that byte outright.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            secs_r <= 32'h0000_0000;
        end else if (ce) begin
            if (sec_wr) begin
                secs_r[ptr_r[1:0]*8 +: 8] <= wdata_hold_r;
            end else if (sec_tick) begin
                secs_r <= secs_r + 32'h0000_0001;
            end
        end
    end

    // Reads come from the shadow so a carry cannot tear a multibyte read.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shadow_r <= 32'h0000_0000;
        end else if (ce && do_snap) begin
            shadow_r <= secs_r;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
        end else if (ce && do_wr && ptr_r == ADDR_CTRL) begin
            ctrl_r <= wdata_hold_r & CTRL_WMASK;
        end
    end

    // ************************************************************
    // Countdown counter
    // ************************************************************
    logic [23:0] seed_r;
    logic [23:0] count_r;
    logic cd_active, wd_mode, cd_wr, cd_rd, pulse_on;
    logic wd_expire, alm_expire;
    logic [27:0] pulse_cnt_r;
    assign wd_mode = ctrl_r[CTRL_WD_SEL];
    assign cd_active = ctrl_r[CTRL_CD_EN] && seed_r != 24'h000000;
    assign cd_wr = do_wr && ptr_r >= ADDR_CD0 && ptr_r <= ADDR_CD2;
    assign cd_rd = do_rd && ptr_r >= ADDR_CD0 && ptr_r <= ADDR_CD2;
    assign pulse_on = pulse_cnt_r != 28'h0000000;
    assign alm_expire = cd_active && !wd_mode && sec_tick
                        && count_r <= 24'h000001;
    assign wd_expire = cd_active && wd_mode && wd_tick && !pulse_on
                       && !cd_rd && !strobe_rise
                       && count_r == 24'h000001;

    // Seed holds the written value; in storage mode it is all there is.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seed_r <= 24'h000000;
        end else if (ce && cd_wr) begin
            seed_r[(ptr_r - ADDR_CD0)*8 +: 8] <= wdata_hold_r;
        end
    end

    // Live count: reload on write, watchdog read or strobe, else decrement.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_r <= 24'h000000;
        end else if (ce) begin
            if (cd_wr) begin
                count_r <= seed_r;
                count_r[(ptr_r - ADDR_CD0)*8 +: 8] <= wdata_hold_r;
            end else if (!cd_active) begin
                count_r <= seed_r;
            end else if (wd_mode && (cd_rd || strobe_rise)) begin
                count_r <= seed_r;
            end else if (alm_expire) begin
                count_r <= seed_r;
            end else if (!wd_mode && sec_tick) begin
                count_r <= count_r - 24'h000001;
            end else if (wd_mode && wd_tick && !pulse_on
                         && count_r != 24'h000000) begin
                count_r <= count_r - 24'h000001;
            end
        end
    end

    // ************************************************************
    // Flags
    // ************************************************************
    logic cd_flag_r, halt_flag_r;
    logic [12:0] stall_cnt_r;
    logic flag_wr;
    logic osc_stopped;
    assign flag_wr = do_wr && ptr_r == ADDR_FLAGS;
    assign osc_stopped = !osc_run || stall_cnt_r >= 13'(STALL_LEN);

    // Countdown flag: set wins over clear; writing one does nothing.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cd_flag_r <= 1'b0;
        end else if (ce) begin
            if (alm_expire || wd_expire) begin
                cd_flag_r <= 1'b1;
            end else if (flag_wr && !wdata_hold_r[FLAG_CD]) begin
                cd_flag_r <= 1'b0;
            end else if (pulse_cnt_r == 28'h0000001) begin
                cd_flag_r <= 1'b0;
            end
        end
    end

    // Halt flag starts set, as after first power, and is sticky.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            halt_flag_r <= 1'b1;
        end else if (ce) begin
            if (osc_stopped) begin
                halt_flag_r <= 1'b1;
            end else if (flag_wr && !wdata_hold_r[FLAG_HALT]) begin
                halt_flag_r <= 1'b0;
            end
        end
    end

    // Missing oscillator edges also count as a stop.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stall_cnt_r <= 13'h0000;
        end else if (ce) begin
            if (osc_rise || !osc_run) begin
                stall_cnt_r <= 13'h0000;
            end else if (stall_cnt_r < 13'(STALL_LEN)) begin
                stall_cnt_r <= stall_cnt_r + 13'h0001;
            end
        end
    end

    // ************************************************************
    // Watchdog pulse timer and output pin
    // ************************************************************
    // The pulse runs on its own count, so flag or enable writes cannot cut it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_cnt_r <= 28'h0000000;
        end else if (ce) begin
            if (wd_expire && ctrl_r[CTRL_PIN_SEL] && ctrl_r[CTRL_IRQ_EN]) begin
                pulse_cnt_r <= 28'(PULSE_LEN);
            end else if (pulse_on) begin
                pulse_cnt_r <= pulse_cnt_r - 28'h0000001;
            end
        end
    end

    logic wave_lvl;
    logic pin_low;
    always_comb begin
        unique case ({ctrl_r[CTRL_RATE_HI], ctrl_r[CTRL_RATE_LO]})
            RATE_1HZ: wave_lvl = sec_div_r[11];
            RATE_4K: wave_lvl = presc_r[2];
            RATE_8K: wave_lvl = presc_r[1];
            default: wave_lvl = osc_s2_r;
        endcase
    end

    // Open drain: only ever drives low; high level is left to the pull-up.
    always_comb begin
        if (!ctrl_r[CTRL_PIN_SEL]) begin
            pin_low = osc_run && !wave_lvl;
        end else if (pulse_on) begin
            pin_low = 1'b1;
        end else begin
            pin_low = ctrl_r[CTRL_IRQ_EN] && !wd_mode && cd_active
                      && cd_flag_r;
        end
    end

    assign wave_or_irq_out = 1'b0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wave_or_irq_oe <= 1'b0;
        end else if (ce) begin
            wave_or_irq_oe <= pin_low;
        end
    end

    // ************************************************************
    // Read data for the link
    // ************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (ptr_r <= ADDR_SEC3) begin
            rd_byte = shadow_r[ptr_r[1:0]*8 +: 8];
        end else if (ptr_r <= ADDR_CD2) begin
            rd_byte = count_r[(ptr_r - ADDR_CD0)*8 +: 8];
        end else if (ptr_r == ADDR_CTRL) begin
            rd_byte = ctrl_r;
        end else if (ptr_r == ADDR_FLAGS) begin
            rd_byte[FLAG_HALT] = halt_flag_r;
            rd_byte[FLAG_CD] = cd_flag_r;
        end
    end

    // Stable from the ack toggle until the next read is taken.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_hold_r <= 8'h00;
        end else if (do_rd) begin
            rdata_hold_r <= rd_byte;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_ptr_wraps: assert property (@(posedge ref_clk) disable iff (rst)
        (do_wr || do_rd) && ptr_r == ADDR_LAST |=> ptr_r == ADDR_FIRST)
        else $error("pointer did not wrap to zero");
    a_snap_copy: assert property (@(posedge ref_clk) disable iff (rst)
        do_snap |=> shadow_r == $past(secs_r))
        else $error("shadow not loaded from running count");
    a_sec_write_div: assert property (@(posedge ref_clk)
        disable iff (rst) ce && sec_wr |=> sec_div_r == 12'h000)
        else $error("seconds divider not reset by write");
    a_disabled_holds: assert property (@(posedge ref_clk)
        disable iff (rst) ce && seed_r == 24'h000000 && !cd_wr
        |=> count_r == 24'h000000 && !$rose(cd_flag_r))
        else $error("zero countdown still counting");
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        cd_flag_r && !(flag_wr && !wdata_hold_r[FLAG_CD]) && !pulse_on
        |=> cd_flag_r)
        else $error("countdown flag cleared without a write");
    a_alarm_pin: assert property (@(posedge ref_clk) disable iff (rst)
        ce && ctrl_r[CTRL_PIN_SEL] && ctrl_r[CTRL_IRQ_EN] && !wd_mode
        && cd_active && cd_flag_r && !pulse_on |=> wave_or_irq_oe)
        else $error("alarm not driven on the pin");
    a_wd_halts: assert property (@(posedge ref_clk) disable iff (rst)
        ce && wd_expire && !cd_wr |=> count_r == 24'h000000 && cd_flag_r)
        else $error("watchdog did not halt with flag set");
    a_pulse_holds: assert property (@(posedge ref_clk)
        disable iff (rst)
        ce && pulse_cnt_r > 28'h0000001 |=> pulse_on ##1 wave_or_irq_oe)
        else $error("watchdog pulse cut short");
    a_no_set_write: assert property (@(posedge ref_clk)
        disable iff (rst)
        !cd_flag_r && !alm_expire && !wd_expire |=> !cd_flag_r)
        else $error("countdown flag set without expiry");
    a_osc_halt: assert property (@(posedge ref_clk) disable iff (rst)
        ce && ctrl_r[CTRL_OSC_DIS] |=> halt_flag_r)
        else $error("halt flag not set with oscillator off");

endmodule // seconds_timekeeper

`default_nettype wire

// ---- link_host.sv ----
// Link host model that issues register requests to the timekeeper.
`timescale 1ns/100ps
`default_nettype none

module link_host
    import seconds_pkg::*;
(
    input wire logic link_clk,
    input wire logic link_busy,
    input wire logic [7:0] link_rdata,
    output logic link_start,
    output logic link_stop,
    output logic link_addr_wr,
    output logic link_data_wr,
    output logic link_data_rd,
    output logic [7:0] link_wdata,
    output logic hung
);
    // Idle state; the host only speaks after reset has gone.
    initial begin
        {link_start, link_stop, link_addr_wr, link_data_wr} = 4'h0;
        link_data_rd = 1'b0;
        link_wdata = 8'h00;
        hung = 1'b0;
    end

    // One request: a single-edge pulse, then a bounded wait for busy to drop.
    // Data is inverted after the pulse so nothing leans on a stale byte.
    task automatic op(input logic [2:0] k, input logic [7:0] d,
                      output logic [7:0] q);
        int i;
        @(posedge link_clk) #1;
        {link_start, link_stop, link_addr_wr, link_data_wr, link_data_rd} =
            5'h10 >> (k - OP_START);
        link_wdata = d;
        @(posedge link_clk) #1;
        {link_start, link_stop, link_addr_wr, link_data_wr} = 4'h0;
        link_data_rd = 1'b0;
        link_wdata = ~d;
        for (i = 0; i < 20 && link_busy !== 1'b0; i++) begin
            @(posedge link_clk) #1;
        end
        hung = (link_busy !== 1'b0);
        q = link_rdata;
    endtask
endmodule // link_host

`default_nettype wire

// ---- seconds_timekeeper_bench.sv ----
// Self-checking bench for the elapsed-seconds timekeeper.
`timescale 1ns/100ps
`default_nettype none

module seconds_timekeeper_bench;
    import seconds_pkg::*;
    localparam int PULSE = 200;
    localparam logic [7:0] CTL [5] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h86};
    localparam int RISE [5] = '{8, 16, 64, 0, 0};
    logic ref_clk = 0;
    logic link_clk = 0;
    logic osc_clk = 0;
    logic rst = 1;
    logic strobe_input = 0;
    logic link_start, link_stop, link_addr_wr, link_data_wr, link_data_rd;
    logic link_busy, wave_or_irq_out, wave_or_irq_oe, hung;
    logic [7:0] link_wdata, link_rdata, q;
    int mismatches = 0;
    int n_tests = 0;
    int n;

    // Unrelated clocks; the oscillator is sped up so ticks fit the run.
    always #12.5 ref_clk = ~ref_clk;
    always #40 link_clk = ~link_clk;
    always #100 osc_clk = ~osc_clk;

    seconds_timekeeper #(.PULSE_LEN(PULSE), .STALL_LEN(64)) DUT (
        .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .osc_clk(osc_clk),
        .strobe_input(strobe_input), .link_clk(link_clk),
        .link_start(link_start), .link_stop(link_stop),
        .link_addr_wr(link_addr_wr), .link_data_wr(link_data_wr),
        .link_data_rd(link_data_rd), .link_wdata(link_wdata),
        .link_busy(link_busy), .link_rdata(link_rdata),
        .wave_or_irq_out(wave_or_irq_out), .wave_or_irq_oe(wave_or_irq_oe));

    link_host host (
        .link_clk(link_clk), .link_busy(link_busy), .link_rdata(link_rdata),
        .link_start(link_start), .link_stop(link_stop),
        .link_addr_wr(link_addr_wr), .link_data_wr(link_data_wr),
        .link_data_rd(link_data_rd), .link_wdata(link_wdata), .hung(hung));

    // Compare one byte and count the outcome.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run.
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A request that never completes ends the run as a failure.
    task automatic go(input logic [2:0] k, input logic [7:0] d);
        host.op(k, d, q);
        if (hung) begin
            mismatches++;
            results();
        end
    endtask

    // Count pin rises over a number of system cycles.
    task automatic rises(input int cyc);
        logic p;
        n = 0;
        p = wave_or_irq_oe;
        repeat (cyc) begin
            @(posedge ref_clk) #1;
            n += int'(wave_or_irq_oe === 1'b1 && p === 1'b0);
            p = wave_or_irq_oe;
        end
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 rst = 0;
        go(OP_ADDR, 8'h07);
        go(OP_READ, 8'h00);
        check(q, CTRL_RESET);
        go(OP_READ, 8'h00);
        check(q, 8'h80);
        go(OP_READ, 8'h00);
        check(q, 8'h00);
        go(OP_ADDR, 8'h08);
        go(OP_WRITE, 8'hFF);
        go(OP_ADDR, 8'h08);
        go(OP_READ, 8'h00);
        check(q, 8'h80);
        go(OP_ADDR, 8'h00);
        for (int i = 0; i < 4; i++) go(OP_WRITE, 8'(32'h12345678 >> 8 * i));
        for (int i = 0; i < 3; i++) go(OP_WRITE, 8'hA5 ^ 8'(i));
        go(OP_START, 8'h00);
        go(OP_ADDR, 8'h00);
        for (int i = 0; i < 7; i++) begin
            go(OP_READ, 8'h00);
            check(q, i < 4 ? 8'(32'h12345678 >> 8 * i)
                           : 8'hA5 ^ 8'(i - 4));
        end
        // Pin source and wave rates; a stopped oscillator gives no wave.
        for (int i = 0; i < 5; i++) begin
            go(OP_ADDR, 8'h07);
            go(OP_WRITE, CTL[i]);
            rises(512);
            check(8'(n >= RISE[i] - 1 && n <= RISE[i] + 1),
                  8'h01);
        end
        go(OP_ADDR, 8'h07);
        go(OP_WRITE, 8'h29);
        go(OP_READ, 8'h00);
        check(q, 8'h80);
        // The read wrapped the pointer, so aim at the flags again to clear.
        go(OP_ADDR, 8'h08);
        go(OP_WRITE, 8'h00);
        go(OP_ADDR, 8'h04);
        go(OP_WRITE, 8'h03);
        go(OP_WRITE, 8'h00);
        go(OP_WRITE, 8'h00);
        go(OP_WRITE, 8'h69);
        n = 0;
        while (wave_or_irq_oe !== 1'b1 && n < 400) begin
            @(posedge ref_clk) #1;
            n++;
        end
        check(8'(n > 100 && n < 240), 8'h01);
        // Clearing the flag mid-pulse must not shorten the pulse.
        fork
            begin
                n = 0;
                while (wave_or_irq_oe === 1'b1 && n < 400) begin
                    n++;
                    @(posedge ref_clk) #1;
                end
            end
            begin
                go(OP_ADDR, 8'h08);
                go(OP_READ, 8'h00);
                check(q, 8'h01);
                go(OP_ADDR, 8'h08);
                go(OP_WRITE, 8'h00);
            end
        join
        check(8'(n), 8'(PULSE));
        go(OP_ADDR, 8'h08);
        go(OP_READ, 8'h00);
        check(q, 8'h00);
        rises(400);
        check(8'(n), 8'h00);
        check({7'h00, wave_or_irq_out}, 8'h00);
        results();
    end
endmodule // seconds_timekeeper_bench

`default_nettype wire
